//--- core/dfs_pkg.sv
package dfs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned HV_TRIP_MS = 5000;
  localparam int unsigned OV_TRIP_MS = 5000;
  localparam int unsigned UV_TRIP_MS = 2000;
  localparam int unsigned PEAK_TRIP_MS = 1000;

  localparam logic [7:0] INV_WARN_PCT = 8'h62;
  localparam logic [7:0] INV_TRIP_PCT = 8'h64;
  localparam logic [7:0] INV_RESET_PCT = 8'h5A;
  localparam logic [7:0] MOT_TRIP_PCT = 8'h64;

  localparam logic [2:0] TMO_FUNC_OFF = 3'h0;
  localparam logic [2:0] TMO_FUNC_STOP_TRIP = 3'h5;

  localparam logic [6:0] CODE_NONE = 7'h00;
  localparam logic [6:0] CODE_LIVE_ZERO = 7'h02;
  localparam logic [6:0] CODE_PHASE_LOSS = 7'h04;
  localparam logic [6:0] CODE_VOLT_HIGH = 7'h05;
  localparam logic [6:0] CODE_VOLT_LOW = 7'h06;
  localparam logic [6:0] CODE_OVERVOLT = 7'h07;
  localparam logic [6:0] CODE_UNDERVOLT = 7'h08;
  localparam logic [6:0] CODE_INV_OVERLOAD = 7'h09;
  localparam logic [6:0] CODE_MOT_OVERLOAD = 7'h0A;
  localparam logic [6:0] CODE_THERMISTOR = 7'h0B;
  localparam logic [6:0] CODE_CURR_LIMIT = 7'h0C;
  localparam logic [6:0] CODE_OVERCURRENT = 7'h0D;
  localparam logic [6:0] CODE_EARTH = 7'h0E;
  localparam logic [6:0] CODE_SWITCH_MODE = 7'h0F;
  localparam logic [6:0] CODE_SHORT = 7'h10;
  localparam logic [6:0] CODE_STD_TIMEOUT = 7'h11;
  localparam logic [6:0] CODE_FB_TIMEOUT = 7'h12;
  localparam logic [6:0] CODE_FREQ_RANGE = 7'h21;
  localparam logic [6:0] CODE_FB_COMM = 7'h22;
  localparam logic [6:0] CODE_INRUSH = 7'h23;
  localparam logic [6:0] CODE_OVERTEMP = 7'h24;
  localparam logic [6:0] CODE_INTERNAL = 7'h25;
  localparam logic [3:0] INTERNAL_LAST = 4'h8;
  localparam logic [6:0] CODE_LOCKED = 7'h63;

  localparam logic [2:0] PIN_SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    DFS_READY   = 2'b00,
    DFS_TRIPPED = 2'b01,
    DFS_LOCKED  = 2'b11
  } dfs_state_type;
endpackage

//--- core/dfs_delay_timer.sv
`timescale 1ns/100ps
module dfs_delay_timer #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk,  // System clock
  input  wire logic             resetn,    // Asynchronous reset, low active
  input  wire logic             tick,      // Time base pulse
  input  wire logic             arm,       // Condition that runs the timer
  input  wire logic [WIDTH-1:0] limit,     // Ticks before expiry
  output logic                  expired    // Condition held for limit ticks
);
  logic [WIDTH-1:0] count_reg;

  if (WIDTH < 2) begin : g_bad_width
    $error("dfs_delay_timer: WIDTH below 2");
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (!arm) begin
      count_reg <= '0;
    end else if (tick && count_reg < limit) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      expired <= 1'b0;
    end else begin
      expired <= arm && (count_reg >= limit);
    end
  end
endmodule // dfs_delay_timer

//--- core/dfs_supervisor.sv
`timescale 1ns/100ps
module dfs_supervisor #(
  parameter int unsigned TICK_CYCLES = dfs_pkg::TICK_CYCLES,
  parameter int unsigned MS_WIDTH    = 16
) (
  input  wire logic          core_clk,         // 125 MHz system clock
  input  wire logic          resetn,           // Power-on reset, low active
  input  wire logic          mains_present,    // Supply present pin
  input  wire logic          three_phase,      // Fed from three-phase supply
  input  wire logic          phase_loss_raw,   // Mains phase missing
  input  wire logic [11:0]   analog_in,        // Analog input level
  input  wire logic [11:0]   analog_min_scale, // Configured minimum scaling
  input  wire logic [11:0]   dc_link_voltage,  // Measured DC-link voltage
  input  wire logic [11:0]   dc_overvolt_lim,  // Overvoltage limit
  input  wire logic [11:0]   dc_warn_high_lim, // High warning level
  input  wire logic [11:0]   dc_warn_low_lim,  // Low warning level
  input  wire logic [11:0]   dc_undervolt_lim, // Undervoltage limit
  input  wire logic [7:0]    inv_thermal_pct,  // Inverter thermal counter
  input  wire logic [7:0]    mot_thermal_pct,  // Motor thermal counter
  input  wire logic          mot_prot_alarm,   // 1: motor faults alarm
  input  wire logic          thermistor_hot,   // Motor thermistor tripped
  input  wire logic [11:0]   output_current,   // Output current
  input  wire logic [11:0]   current_limit,    // Configured current limit
  input  wire logic [15:0]   oc_trip_delay_ms, // Current-limit trip delay
  input  wire logic          peak_over_limit,  // Peak above twice rated
  input  wire logic          earth_fault,      // Earth fault comparator
  input  wire logic          switch_mode_fault,// Internal supply fault
  input  wire logic          short_circuit,    // Output short circuit
  input  wire logic          inrush_fault,     // Too many power-ups
  input  wire logic          internal_fault,   // Internal fault present
  input  wire logic [3:0]    internal_index,   // Internal fault number
  input  wire logic          fb_comm_fault,    // Option card fault
  input  wire logic          overtemp,         // Power module too hot
  input  wire logic          panel_locked,     // Panel keys locked
  input  wire logic          std_bus_silent,   // Serial timeout elapsed
  input  wire logic [2:0]    std_tmo_func,     // Serial timeout function
  input  wire logic          fb_bus_silent,    // Fieldbus timeout elapsed
  input  wire logic [2:0]    fb_tmo_func,      // Fieldbus timeout function
  input  wire logic          ramp_done,        // Ramp down finished
  input  wire logic          freq_at_limit,    // Output at frequency limit
  input  wire logic          closed_loop_mode, // Closed-loop process mode
  input  wire logic          reset_key,        // Stop/reset key pin
  input  wire logic          reset_din,        // Reset digital input pin
  input  wire logic          ser_reset_cmd,    // Serial reset command pulse
  input  wire logic          auto_reset_en,    // Automatic reset selected
  output logic [6:0]         fault_code_display, // Shown code, 0 none
  output logic               display_flash,    // Code flashes
  output logic               warn_led,         // Yellow indication
  output logic               alarm_led,        // Red indication
  output logic               trip_locked,      // Locking trip latched
  output logic               coast_motor,      // Motor let coast
  output logic               inverter_disable, // Inverter switched off
  output logic               ramp_down_req,    // Ramp down for bus trip
  output logic               drive_ready,      // Ready to start
  output logic               ext_freq_range,   // Extended status bit
  output logic               reset_refused     // Last reset refused
);
  localparam logic [MS_WIDTH-1:0] HV_LIM = MS_WIDTH'(dfs_pkg::HV_TRIP_MS);
  localparam logic [MS_WIDTH-1:0] OV_LIM = MS_WIDTH'(dfs_pkg::OV_TRIP_MS);
  localparam logic [MS_WIDTH-1:0] UV_LIM = MS_WIDTH'(dfs_pkg::UV_TRIP_MS);
  localparam logic [MS_WIDTH-1:0] PK_LIM = MS_WIDTH'(dfs_pkg::PEAK_TRIP_MS);
  localparam int unsigned PW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2 || MS_WIDTH < 16) begin : g_bad_param
    $error("dfs_supervisor: TICK_CYCLES or MS_WIDTH too small");
  end

  dfs_pkg::dfs_state_type state_reg;
  logic [PW-1:0]   presc_reg;
  logic            tick_reg;
  logic [7:0]      blink_cnt_reg;
  logic            blink_reg;
  logic [2:0]      s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg;
  logic            key_edge, din_edge, mains_ok;
  logic [6:0]      alarm_code_reg;
  logic            pwr_cycled_reg;
  logic            inv_off_d_reg;
  logic            over_v, high_v, low_v, under_v;
  logic            hv_exp, ov_exp, uv_exp, oc_exp, pk_exp;
  logic            over_curr, std_on, fb_on, std_trip, fb_trip;
  logic            alarm_req, alarm_lock;
  logic [6:0]      alarm_code;
  logic [6:0]      warn_code;
  logic            manual_reset, auto_reset, int_reset, any_reset;
  logic            reset_ok;

  // Time base shared by every delay and the blink
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (presc_reg == PW'(TICK_CYCLES - 1)) begin
      presc_reg <= '0;
      tick_reg  <= 1'b1;
    end else begin
      presc_reg <= presc_reg + 1'b1;
      tick_reg  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (tick_reg) begin
      if (blink_cnt_reg == 8'(dfs_pkg::BLINK_MS - 1)) begin
        blink_cnt_reg <= '0;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  // Pins: three stages, level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg    <= dfs_pkg::PIN_SYNC_RESET;
      s2_reg    <= dfs_pkg::PIN_SYNC_RESET;
      s3_reg    <= dfs_pkg::PIN_SYNC_RESET;
      lvl_reg   <= dfs_pkg::PIN_SYNC_RESET;
      lvl_d_reg <= dfs_pkg::PIN_SYNC_RESET;
    end else begin
      s1_reg    <= {mains_present, reset_din, reset_key};
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
      lvl_d_reg <= lvl_reg;
    end
  end

  assign key_edge = lvl_reg[0] & ~lvl_d_reg[0];
  assign din_edge = lvl_reg[1] & ~lvl_d_reg[1];
  assign mains_ok = lvl_reg[2];

  // Measurement comparisons
  assign over_v    = dc_link_voltage > dc_overvolt_lim;
  assign high_v    = dc_link_voltage > dc_warn_high_lim;
  assign low_v     = dc_link_voltage < dc_warn_low_lim;
  assign under_v   = dc_link_voltage < dc_undervolt_lim;
  assign over_curr = output_current > current_limit;
  assign std_on    = std_bus_silent && std_tmo_func != dfs_pkg::TMO_FUNC_OFF;
  assign fb_on     = fb_bus_silent && fb_tmo_func != dfs_pkg::TMO_FUNC_OFF;
  assign std_trip  = std_on && std_tmo_func == dfs_pkg::TMO_FUNC_STOP_TRIP;
  assign fb_trip   = fb_on && fb_tmo_func == dfs_pkg::TMO_FUNC_STOP_TRIP;

  dfs_delay_timer #(.WIDTH(MS_WIDTH)) u_hv_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_reg),
    .arm      (high_v),
    .limit    (HV_LIM),
    .expired  (hv_exp)
  );

  dfs_delay_timer #(.WIDTH(MS_WIDTH)) u_ov_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_reg),
    .arm      (over_v),
    .limit    (OV_LIM),
    .expired  (ov_exp)
  );

  dfs_delay_timer #(.WIDTH(MS_WIDTH)) u_uv_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_reg),
    .arm      (under_v),
    .limit    (UV_LIM),
    .expired  (uv_exp)
  );

  dfs_delay_timer #(.WIDTH(MS_WIDTH)) u_oc_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_reg),
    .arm      (over_curr),
    .limit    (MS_WIDTH'(oc_trip_delay_ms)),
    .expired  (oc_exp)
  );

  dfs_delay_timer #(.WIDTH(MS_WIDTH)) u_pk_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_reg),
    .arm      (peak_over_limit),
    .limit    (PK_LIM),
    .expired  (pk_exp)
  );

  // Trip requests; locking sources win over non-locking ones
  always_comb begin
    alarm_req  = 1'b1;
    alarm_lock = 1'b1;
    alarm_code = dfs_pkg::CODE_NONE;
    if (internal_fault && internal_index <= dfs_pkg::INTERNAL_LAST) begin
      alarm_code = dfs_pkg::CODE_INTERNAL + {3'h0, internal_index};
    end else if (short_circuit) begin
      alarm_code = dfs_pkg::CODE_SHORT;
    end else if (earth_fault) begin
      alarm_code = dfs_pkg::CODE_EARTH;
    end else if (switch_mode_fault) begin
      alarm_code = dfs_pkg::CODE_SWITCH_MODE;
    end else if (inrush_fault) begin
      alarm_code = dfs_pkg::CODE_INRUSH;
    end else if (pk_exp) begin
      alarm_code = dfs_pkg::CODE_OVERCURRENT;
    end else if (ov_exp || hv_exp) begin
      alarm_code = dfs_pkg::CODE_OVERVOLT;
    end else if (uv_exp) begin
      alarm_code = dfs_pkg::CODE_UNDERVOLT;
    end else if (three_phase && phase_loss_raw) begin
      alarm_code = dfs_pkg::CODE_PHASE_LOSS;
    end else begin
      alarm_lock = 1'b0;
      if (inv_thermal_pct >= dfs_pkg::INV_TRIP_PCT) begin
        alarm_code = dfs_pkg::CODE_INV_OVERLOAD;
      end else if (mot_prot_alarm && mot_thermal_pct >= dfs_pkg::MOT_TRIP_PCT) begin
        alarm_code = dfs_pkg::CODE_MOT_OVERLOAD;
      end else if (mot_prot_alarm && thermistor_hot) begin
        alarm_code = dfs_pkg::CODE_THERMISTOR;
      end else if (oc_exp) begin
        alarm_code = dfs_pkg::CODE_CURR_LIMIT;
      end else if (std_trip && ramp_done) begin
        alarm_code = dfs_pkg::CODE_STD_TIMEOUT;
      end else if (fb_trip && ramp_done) begin
        alarm_code = dfs_pkg::CODE_FB_TIMEOUT;
      end else if (fb_comm_fault) begin
        alarm_code = dfs_pkg::CODE_FB_COMM;
      end else if (overtemp) begin
        alarm_code = dfs_pkg::CODE_OVERTEMP;
      end else if (analog_in < (analog_min_scale >> 1)) begin
        alarm_code = dfs_pkg::CODE_LIVE_ZERO;
      end else begin
        alarm_req = 1'b0;
      end
    end
  end

  // Warnings follow their conditions and are never latched
  always_comb begin
    warn_code = dfs_pkg::CODE_NONE;
    if (peak_over_limit) begin
      warn_code = dfs_pkg::CODE_OVERCURRENT;
    end else if (three_phase && phase_loss_raw) begin
      warn_code = dfs_pkg::CODE_PHASE_LOSS;
    end else if (over_v) begin
      warn_code = dfs_pkg::CODE_OVERVOLT;
    end else if (under_v) begin
      warn_code = dfs_pkg::CODE_UNDERVOLT;
    end else if (inv_thermal_pct >= dfs_pkg::INV_WARN_PCT) begin
      warn_code = dfs_pkg::CODE_INV_OVERLOAD;
    end else if (!mot_prot_alarm && mot_thermal_pct >= dfs_pkg::MOT_TRIP_PCT) begin
      warn_code = dfs_pkg::CODE_MOT_OVERLOAD;
    end else if (thermistor_hot) begin
      warn_code = dfs_pkg::CODE_THERMISTOR;
    end else if (over_curr) begin
      warn_code = dfs_pkg::CODE_CURR_LIMIT;
    end else if (std_on) begin
      warn_code = dfs_pkg::CODE_STD_TIMEOUT;
    end else if (fb_on) begin
      warn_code = dfs_pkg::CODE_FB_TIMEOUT;
    end else if (fb_comm_fault) begin
      warn_code = dfs_pkg::CODE_FB_COMM;
    end else if (overtemp) begin
      warn_code = dfs_pkg::CODE_OVERTEMP;
    end else if (analog_in < (analog_min_scale >> 1)) begin
      warn_code = dfs_pkg::CODE_LIVE_ZERO;
    end else if (high_v) begin
      warn_code = dfs_pkg::CODE_VOLT_HIGH;
    end else if (low_v) begin
      warn_code = dfs_pkg::CODE_VOLT_LOW;
    end else if (freq_at_limit && closed_loop_mode) begin
      warn_code = dfs_pkg::CODE_FREQ_RANGE;
    end else if (panel_locked) begin
      warn_code = dfs_pkg::CODE_LOCKED;
    end
  end

  // Reset sources
  assign manual_reset = key_edge | din_edge | ser_reset_cmd;
  assign auto_reset   = auto_reset_en && !alarm_req;
  assign int_reset    = inverter_disable && !inv_off_d_reg;
  assign any_reset    = manual_reset | auto_reset | int_reset;
  // Inverter overload cannot be cleared while the counter is still hot
  assign reset_ok = !(alarm_code_reg == dfs_pkg::CODE_INV_OVERLOAD &&
                      inv_thermal_pct >= dfs_pkg::INV_RESET_PCT);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      inv_off_d_reg <= 1'b0;
    end else begin
      inv_off_d_reg <= inverter_disable;
    end
  end

  // Supply loss while locked arms the next reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_cycled_reg <= 1'b0;
    end else if (state_reg != dfs_pkg::DFS_LOCKED) begin
      pwr_cycled_reg <= 1'b0;
    end else if (!mains_ok) begin
      pwr_cycled_reg <= 1'b1;
    end
  end

  // Trip state; a new trip request wins over a reset in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= dfs_pkg::DFS_READY;
      alarm_code_reg <= dfs_pkg::CODE_NONE;
      reset_refused  <= 1'b0;
    end else begin
      case (state_reg)
        dfs_pkg::DFS_READY: begin
          if (alarm_req) begin
            state_reg      <= alarm_lock ? dfs_pkg::DFS_LOCKED : dfs_pkg::DFS_TRIPPED;
            alarm_code_reg <= alarm_code;
          end
        end
        dfs_pkg::DFS_TRIPPED: begin
          if (alarm_req && alarm_lock) begin
            state_reg      <= dfs_pkg::DFS_LOCKED;
            alarm_code_reg <= alarm_code;
          end else if (any_reset && !alarm_req && reset_ok) begin
            state_reg      <= dfs_pkg::DFS_READY;
            alarm_code_reg <= dfs_pkg::CODE_NONE;
            reset_refused  <= 1'b0;
          end else if (manual_reset && !reset_ok) begin
            reset_refused  <= 1'b1;
          end
        end
        dfs_pkg::DFS_LOCKED: begin
          if (manual_reset && pwr_cycled_reg && mains_ok && !alarm_req) begin
            state_reg      <= dfs_pkg::DFS_READY;
            alarm_code_reg <= dfs_pkg::CODE_NONE;
          end
        end
        default: begin
          state_reg      <= dfs_pkg::DFS_LOCKED;
          alarm_code_reg <= dfs_pkg::CODE_NONE;
        end
      endcase
    end
  end

  // Display and indications
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fault_code_display <= dfs_pkg::CODE_NONE;
      display_flash      <= 1'b0;
      warn_led           <= 1'b0;
      alarm_led          <= 1'b0;
    end else if (state_reg != dfs_pkg::DFS_READY) begin
      fault_code_display <= alarm_code_reg;
      display_flash      <= 1'b1;
      alarm_led          <= blink_reg;
      // Yellow joins while the cause persists; a locked trip shows both
      warn_led           <= (state_reg == dfs_pkg::DFS_LOCKED) ? blink_reg :
                            (alarm_req ? blink_reg : 1'b0);
    end else begin
      fault_code_display <= warn_code;
      display_flash      <= 1'b0;
      alarm_led          <= 1'b0;
      warn_led           <= warn_code != dfs_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      inverter_disable <= 1'b0;
      ramp_down_req    <= 1'b0;
      ext_freq_range   <= 1'b0;
    end else begin
      inverter_disable <= over_v || under_v;
      ramp_down_req    <= std_trip || fb_trip;
      ext_freq_range   <= freq_at_limit && !closed_loop_mode;
    end
  end

  assign trip_locked = state_reg == dfs_pkg::DFS_LOCKED;
  assign coast_motor = state_reg != dfs_pkg::DFS_READY;
  assign drive_ready = state_reg == dfs_pkg::DFS_READY && mains_ok;
endmodule // dfs_supervisor

//--- test/dfs_supervisor_sva.sv
`timescale 1ns/100ps
module dfs_supervisor_sva (
  input wire logic        core_clk, resetn, mains_present, three_phase, phase_loss_raw, earth_fault,
  input wire logic        switch_mode_fault, short_circuit, inrush_fault, freq_at_limit, closed_loop_mode,
  input wire logic [11:0] dc_link_voltage, dc_overvolt_lim, dc_undervolt_lim,
  input wire logic        display_flash, trip_locked, coast_motor, inverter_disable, drive_ready, ext_freq_range
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_ready_runs: assert property (drive_ready |-> !coast_motor)
    else $error("Ready while coasting");
  chk_lock_stops: assert property (trip_locked |-> coast_motor && !drive_ready)
    else $error("Locked but not stopped");
  chk_hard_lock: assert property (
    (earth_fault || switch_mode_fault || short_circuit || inrush_fault) |=> trip_locked)
    else $error("Locking fault did not lock");
  chk_phase_lock: assert property ((three_phase && phase_loss_raw) |=> trip_locked)
    else $error("Phase loss did not lock");
  chk_mains_gone: assert property (!mains_present [*6] |-> !drive_ready)
    else $error("Ready without supply");
  chk_ovr_off: assert property ((dc_link_voltage > dc_overvolt_lim) [*3] |-> inverter_disable)
    else $error("Inverter on above overvoltage");
  chk_under_off: assert property ((dc_link_voltage < dc_undervolt_lim) [*3] |-> inverter_disable)
    else $error("Inverter on below undervoltage");
  chk_freq_status: assert property ((freq_at_limit && !closed_loop_mode) [*3] |-> ext_freq_range)
    else $error("Status bit missing at frequency limit");
  chk_trip_flash: assert property ($rose(trip_locked) |=> display_flash)
    else $error("Locked code not flashing");
endmodule // dfs_supervisor_sva
bind dfs_supervisor dfs_supervisor_sva chk (.*);

//--- test/dfs_panel_model.sv
`timescale 1ns/100ps
module dfs_panel_model (
  input wire logic core_clk,      // System clock
  output logic     reset_key,     // Stop/reset key
  output logic     reset_din,     // Reset digital input
  output logic     ser_reset_cmd  // Serial reset pulse
);
  initial {reset_key, reset_din, ser_reset_cmd} = 3'h0;
  // Pins are held well past the input synchroniser; the serial command is one cycle only
  task automatic press(input int src);
    @(negedge core_clk);
    case (src)
      0: reset_key = 1'h1;
      1: reset_din = 1'h1;
      default: ser_reset_cmd = 1'h1;
    endcase
    repeat (src == 2 ? 1 : 8) @(negedge core_clk);
    {reset_key, reset_din, ser_reset_cmd} = 3'h0;
  endtask
endmodule // dfs_panel_model

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  logic core_clk, resetn, mains_present, three_phase, phase_loss_raw, mot_prot_alarm, thermistor_hot, peak_over_limit;
  logic earth_fault, switch_mode_fault, short_circuit, inrush_fault, internal_fault, fb_comm_fault, overtemp;
  logic panel_locked, std_bus_silent, fb_bus_silent, ramp_done, freq_at_limit, closed_loop_mode, auto_reset_en;
  logic reset_key, reset_din, ser_reset_cmd, display_flash, warn_led, alarm_led, trip_locked, coast_motor;
  logic inverter_disable, ramp_down_req, drive_ready, ext_freq_range, reset_refused;
  logic [11:0] analog_in, analog_min_scale, dc_link_voltage, dc_overvolt_lim, dc_warn_high_lim, dc_warn_low_lim;
  logic [11:0] dc_undervolt_lim, output_current, current_limit;
  logic [7:0]  inv_thermal_pct, mot_thermal_pct;
  logic [15:0] oc_trip_delay_ms;
  logic [3:0]  internal_index;
  logic [2:0]  std_tmo_func, fb_tmo_func;
  logic [6:0]  fault_code_display;
  int          err_total = 0, check_count = 0, cycles = 0;

  dfs_supervisor #(.TICK_CYCLES(4)) uut (.*);
  dfs_panel_model panel (.*);

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_code(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic s_levels();
    dc_link_voltage = 12'h02ee;
    cyc(3);
    chk_code(fault_code_display, dfs_pkg::CODE_VOLT_HIGH);
    chk_bit(coast_motor, 1'h0);
    chk_bit(warn_led, 1'h1);
    chk_bit(alarm_led, 1'h0);
    dc_link_voltage = 12'h03e8;
    cyc(3);
    chk_bit(inverter_disable, 1'h1);
    dc_link_voltage = 12'h0064;
    cyc(3);
    chk_bit(inverter_disable, 1'h1);
    dc_link_voltage = 12'h01f4;
    phase_loss_raw = 1'h1;
    cyc(3);
    chk_bit(trip_locked, 1'h0);
    chk_code(fault_code_display, dfs_pkg::CODE_NONE);
    phase_loss_raw = 1'h0;
    freq_at_limit = 1'h1;
    cyc(3);
    chk_bit(ext_freq_range, 1'h1);
    chk_code(fault_code_display, dfs_pkg::CODE_NONE);
    closed_loop_mode = 1'h1;
    cyc(3);
    chk_code(fault_code_display, dfs_pkg::CODE_FREQ_RANGE);
    {freq_at_limit, closed_loop_mode} = 2'h0;
  endtask

  task automatic s_sources();
    for (int src = 0; src < 3; src++) begin
      thermistor_hot = 1'h1;
      cyc(3);
      chk_code(fault_code_display, dfs_pkg::CODE_THERMISTOR);
      chk_bit(trip_locked, 1'h0);
      chk_bit(coast_motor, 1'h1);
      thermistor_hot = 1'h0;
      panel.press(src);
      cyc(3);
      chk_bit(drive_ready, 1'h1);
    end
  endtask

  task automatic s_inverter();
    inv_thermal_pct = 8'h62;
    cyc(3);
    chk_code(fault_code_display, dfs_pkg::CODE_INV_OVERLOAD);
    chk_bit(coast_motor, 1'h0);
    inv_thermal_pct = 8'h64;
    cyc(3);
    chk_bit(coast_motor, 1'h1);
    inv_thermal_pct = 8'h5f;
    panel.press(2);
    cyc(2);
    chk_bit(reset_refused, 1'h1);
    chk_bit(coast_motor, 1'h1);
    inv_thermal_pct = 8'h59;
    panel.press(2);
    cyc(2);
    chk_bit(drive_ready, 1'h1);
    chk_bit(reset_refused, 1'h0);
    inv_thermal_pct = 8'h00;
  endtask

  task automatic s_auto();
    {auto_reset_en, thermistor_hot} = 2'h3;
    cyc(3);
    chk_bit(coast_motor, 1'h1);
    thermistor_hot = 1'h0;
    cyc(3);
    chk_bit(drive_ready, 1'h1);
    auto_reset_en = 1'h0;
  endtask

  task automatic s_bus();
    {std_tmo_func, std_bus_silent} = 4'hb;
    cyc(3);
    chk_code(fault_code_display, dfs_pkg::CODE_STD_TIMEOUT);
    chk_bit(ramp_down_req, 1'h1);
    chk_bit(coast_motor, 1'h0);
    ramp_done = 1'h1;
    cyc(3);
    chk_bit(coast_motor, 1'h1);
    {std_tmo_func, std_bus_silent, ramp_done} = '0;
    {fb_tmo_func, fb_bus_silent} = 4'h3;
    panel.press(2);
    cyc(3);
    chk_code(fault_code_display, dfs_pkg::CODE_FB_TIMEOUT);
    chk_bit(ramp_down_req, 1'h0);
    fb_bus_silent = 1'h0;
    {analog_min_scale, analog_in} = {12'h0100, 12'h007f};
    cyc(3);
    chk_bit(coast_motor, 1'h1);
    analog_in = 12'h0080;
    panel.press(2);
    cyc(3);
    chk_bit(drive_ready, 1'h1);
  endtask

  task automatic s_lock(input int sel, input logic [6:0] code);
    if (sel == 0) earth_fault = 1'h1;
    else {three_phase, phase_loss_raw} = 2'h3;
    cyc(3);
    chk_bit(trip_locked, 1'h1);
    chk_code(fault_code_display, code);
    chk_bit(display_flash, 1'h1);
    {earth_fault, three_phase, phase_loss_raw} = 3'h0;
    panel.press(2);
    cyc(3);
    chk_bit(trip_locked, 1'h1);
    mains_present = 1'h0;
    cyc(8);
    mains_present = 1'h1;
    cyc(8);
    panel.press(2);
    cyc(3);
    chk_bit(drive_ready, 1'h1);
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    resetn = 1'h0;
    {three_phase, phase_loss_raw, thermistor_hot, peak_over_limit, earth_fault, switch_mode_fault, short_circuit,
     inrush_fault, internal_fault, fb_comm_fault, overtemp, panel_locked, std_bus_silent, fb_bus_silent, ramp_done,
     freq_at_limit, closed_loop_mode, auto_reset_en} = '0;
    {analog_in, analog_min_scale, output_current, inv_thermal_pct, mot_thermal_pct, internal_index} = '0;
    {std_tmo_func, fb_tmo_func, current_limit, oc_trip_delay_ms} = {6'h00, 12'h0fff, 16'h0100};
    {dc_overvolt_lim, dc_warn_high_lim, dc_warn_low_lim, dc_undervolt_lim} = {12'h0320, 12'h02bc, 12'h012c, 12'h00c8};
    {dc_link_voltage, mains_present, mot_prot_alarm} = {12'h01f4, 2'h3};
    repeat (6) @(negedge core_clk);
    chk_bit(drive_ready, 1'h0);
    resetn = 1'h1;
    cyc(8);
    s_levels();
    s_sources();
    s_inverter();
    s_auto();
    s_bus();
    s_lock(0, dfs_pkg::CODE_EARTH);
    s_lock(1, dfs_pkg::CODE_PHASE_LOSS);
    print_verdict();
  end
endmodule // tb
